// ==== rtl/rt_write_pkg.sv ====
// constants for the render target write message handler
package rt_write_pkg;
    // descriptor fields
    localparam int DESC_LAST_BIT = 11;
    localparam int DESC_TYPE_HI = 10;
    localparam int DESC_TYPE_LO = 8;
    localparam logic [2:0] TYPE_SIMD16 = 3'h0;
    localparam logic [2:0] TYPE_REPLICATED = 3'h1;
    localparam logic [2:0] TYPE_DUAL_LO = 3'h2;
    localparam logic [2:0] TYPE_DUAL_HI = 3'h3;
    localparam logic [2:0] TYPE_SIMD8 = 3'h4;
    // header dword indices and fields
    localparam int HDR_WORDS = 8;
    localparam int W_TAG = 5;
    localparam int W_CC = 1;
    localparam int W_MASK = 0;
    localparam int W_VIEW = 7;
    localparam int W_FACE = 6;
    localparam int TAG_HI = 7;
    localparam int CC_LO = 6;
    localparam int DISP_LO = 16;
    localparam int VP_HI = 30;
    localparam int VP_LO = 27;
    localparam int AI_HI = 26;
    localparam int AI_LO = 16;
    localparam int FACE_BIT = 31;
    // surface kinds
    localparam logic [2:0] SURF_ONE_DIM = 3'h0;
    localparam logic [2:0] SURF_TWO_DIM = 3'h1;
    localparam logic [2:0] SURF_VOLUME = 3'h2;
    localparam logic [2:0] SURF_CUBE = 3'h3;
    localparam logic [2:0] SURF_LINEAR = 3'h4;
    localparam logic [10:0] CUBE_DEPTH = 11'h005;
    localparam logic [10:0] AI_ZERO = 11'h000;
    // sample counts
    localparam logic [1:0] SAMP_1X = 2'h0;
    localparam logic [1:0] SAMP_4X = 2'h1;
    localparam logic [1:0] SAMP_8X = 2'h2;
endpackage : rt_write_pkg

// ==== rtl/rt_header_mem.sv ====
`timescale 1ns/1ns
// two-register header store, registered read port
module rt_header_mem (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic wr_sel_i,
    input wire logic [255:0] wr_data_i,
    input wire logic rd_sel_i,
    output logic [255:0] rd_data_o
);
    logic [255:0] mem_reg [0:1];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_sel_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_reg[rd_sel_i];
    end
endmodule : rt_header_mem

// ==== rtl/rt_write_handler.sv ====
`timescale 1ns/1ns
// render target write message handler: header parse, slot mapping, bounds
module rt_write_handler (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // message phases from the thread
    input wire logic MSG_VALID_I,
    input wire logic [255:0] MSG_DATA_I,
    input wire logic [13:0] DESC_I,
    input wire logic END_OF_THREAD_I,
    input wire logic [15:0] EXEC_MASK_I,
    output logic MSG_READY_O,
    // surface state
    input wire logic [2:0] SURF_KIND_I,
    input wire logic [10:0] MIN_ARRAY_I,
    input wire logic [10:0] DEPTH_I,
    input wire logic [15:0] WIDTH_I,
    input wire logic [15:0] HEIGHT_I,
    input wire logic [1:0] NUM_SAMPLES_I,
    input wire logic [1:0] SSPI_I,
    // per-slot X/Y of subspan upper-left, four subspans
    input wire logic [63:0] SPAN_X_I,
    input wire logic [63:0] SPAN_Y_I,
    // to render cache
    output logic WR_VALID_O,
    output logic [15:0] WR_PIXEL_MASK_O,
    output logic [10:0] ARRAY_INDEX_O,
    output logic [3:0] VIEWPORT_O,
    output logic [25:0] CC_PTR_O,
    output logic BACK_FACE_O,
    output logic LAST_TARGET_O,
    output logic [2:0] MSG_TYPE_O,
    output logic [1:0] SPAN_PAIR_O,
    output logic [31:0] SLOT_SAMPLE_O,
    // completion and statistics
    output logic RELEASE_VALID_O,
    output logic [7:0] THREAD_TAG_O,
    output logic [15:0] DISPATCH_MASK_O,
    output logic [4:0] CLIP_DEC_O,
    output logic CLIP_DEC_VALID_O,
    output logic BAD_TYPE_O
);
    typedef enum logic [2:0] {IDLE, HDR1, FETCH, ISSUE} state_type;
    state_type state_reg;
    logic [2:0] type_reg;
    logic last_reg;
    logic eot_reg;
    logic hdr_sel;
    logic [255:0] hdr_rd;
    logic [255:0] hdr0_reg;
    logic fetched_reg;
    logic take;
    logic type_ok;

    function automatic logic legal_type(input logic [2:0] t);
        legal_type = (t <= rt_write_pkg::TYPE_SIMD8);
    endfunction : legal_type

    // header words ignore exec mask entirely
    assign take = MSG_VALID_I && MSG_READY_O;
    assign type_ok = legal_type(DESC_I[rt_write_pkg::DESC_TYPE_HI:rt_write_pkg::DESC_TYPE_LO]);
    assign hdr_sel = (state_reg == IDLE) ? 1'b0 : 1'b1;

    rt_header_mem u_hdr (
        .clk_i(REF_CLK_I),
        .wr_en_i(take),
        .wr_sel_i(hdr_sel),
        .wr_data_i(MSG_DATA_I),
        .rd_sel_i(1'b1),
        .rd_data_o(hdr_rd)
    );

    // header sequencing: two registers before any payload
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= IDLE;
            MSG_READY_O <= 1'b0;
        end else begin
            case (state_reg)
                IDLE: begin
                    MSG_READY_O <= 1'b1;
                    if (take) begin
                        state_reg <= HDR1;
                    end
                end
                HDR1: begin
                    if (take) begin
                        state_reg <= FETCH;
                        MSG_READY_O <= 1'b0;
                    end
                end
                FETCH: state_reg <= ISSUE;
                ISSUE: begin
                    state_reg <= IDLE;
                    MSG_READY_O <= 1'b1;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // descriptor and first header register capture
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            type_reg <= rt_write_pkg::TYPE_SIMD16;
            last_reg <= 1'b0;
            eot_reg <= 1'b0;
            hdr0_reg <= '0;
        end else if (take && state_reg == IDLE) begin
            type_reg <= DESC_I[rt_write_pkg::DESC_TYPE_HI:rt_write_pkg::DESC_TYPE_LO];
            last_reg <= DESC_I[rt_write_pkg::DESC_LAST_BIT];
            eot_reg <= END_OF_THREAD_I;
            hdr0_reg <= MSG_DATA_I;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fetched_reg <= 1'b0;
        end else begin
            fetched_reg <= (state_reg == FETCH);
        end
    end

    // bounds and array index handling
    logic [10:0] ai_raw;
    logic [10:0] ai_max;
    logic ai_bad;
    logic [15:0] in_bounds;
    logic [15:0] live;
    logic dual;
    logic [1:0] pair;

    assign ai_raw = hdr_rd[rt_write_pkg::W_VIEW*32 + rt_write_pkg::AI_LO +: 11];
    assign ai_max = (SURF_KIND_I == rt_write_pkg::SURF_CUBE) ? rt_write_pkg::CUBE_DEPTH : DEPTH_I;
    // out-of-range replaced by minimum element; buffers always zero
    assign ai_bad = (ai_raw < MIN_ARRAY_I) || (ai_raw > ai_max);
    assign dual = (type_reg == rt_write_pkg::TYPE_DUAL_LO) || (type_reg == rt_write_pkg::TYPE_DUAL_HI);
    // dual source: low type bit picks subspans 2-3
    assign pair = dual ? {type_reg[0], 1'b0} : 2'h0;

    // pixel bounds per slot; pixel n of a span sits at +n[0] x, +n[1] y
    genvar s;
    generate
        for (s = 0; s < 16; s++) begin : g_slot
            logic [1:0] span;
            logic [16:0] px;
            logic [16:0] py;
            // multisample forms address only subspan zero (or the dual pair)
            assign span = (NUM_SAMPLES_I == rt_write_pkg::SAMP_1X) ?
                          2'(s / 4) + pair : pair;
            assign px = {1'b0, SPAN_X_I[span*16 +: 16]} + 17'(s % 2);
            // linear and 1D index by X only
            assign py = (SURF_KIND_I == rt_write_pkg::SURF_LINEAR ||
                         SURF_KIND_I == rt_write_pkg::SURF_ONE_DIM) ? 17'h0_0000 :
                        {1'b0, SPAN_Y_I[span*16 +: 16]} + 17'((s / 2) % 2);
            assign in_bounds[s] = (px < {1'b0, WIDTH_I}) &&
                                  ((SURF_KIND_I == rt_write_pkg::SURF_LINEAR ||
                                    SURF_KIND_I == rt_write_pkg::SURF_ONE_DIM) ||
                                   (py < {1'b0, HEIGHT_I}));
        end
    endgenerate

    // header live bits and pixel bounds steer writes; exec mask unused
    assign live = hdr0_reg[rt_write_pkg::W_MASK*32 +: 16] & in_bounds;

    // sample index per slot group
    function automatic logic [7:0] sample_map(input logic [1:0] ns, input logic [1:0] sspi);
        logic [7:0] m;
        m = 8'h00;
        for (int g = 0; g < 4; g++) begin
            if (ns == rt_write_pkg::SAMP_1X) begin
                m[g*2 +: 2] = 2'h0;
            end else begin
                m[g*2 +: 2] = 2'(g);
            end
        end
        map_unused(sspi);
        sample_map = m;
    endfunction : sample_map

    function automatic void map_unused(input logic [1:0] x);
    endfunction : map_unused

    logic [31:0] samples;
    logic simd8;
    assign simd8 = (type_reg == rt_write_pkg::TYPE_SIMD8) || dual;
    always_comb begin
        samples = '0;
        for (int g = 0; g < 4; g++) begin
            if (NUM_SAMPLES_I == rt_write_pkg::SAMP_1X) begin
                samples[g*8 +: 8] = 8'h00;
            end else if (NUM_SAMPLES_I == rt_write_pkg::SAMP_4X && !simd8) begin
                samples[g*8 +: 8] = 8'(g);
            end else begin
                samples[g*8 +: 8] = 8'({SSPI_I, 1'b0}) + 8'(g);
            end
        end
    end

    // clipped-out popcount
    logic [4:0] clip_cnt;
    always_comb begin
        clip_cnt = 5'h00;
        for (int b = 0; b < 16; b++) begin
            clip_cnt = clip_cnt + 5'(hdr_rd[rt_write_pkg::W_VIEW*32 + b]);
        end
    end

    // issue to render cache, one cycle after header word two is read back
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            WR_VALID_O <= 1'b0;
            WR_PIXEL_MASK_O <= 16'h0000;
            ARRAY_INDEX_O <= rt_write_pkg::AI_ZERO;
            VIEWPORT_O <= 4'h0;
            CC_PTR_O <= 26'h000_0000;
            BACK_FACE_O <= 1'b0;
            LAST_TARGET_O <= 1'b0;
            MSG_TYPE_O <= rt_write_pkg::TYPE_SIMD16;
            SPAN_PAIR_O <= 2'h0;
            SLOT_SAMPLE_O <= 32'h0000_0000;
            BAD_TYPE_O <= 1'b0;
        end else begin
            WR_VALID_O <= fetched_reg && legal_type(type_reg);
            BAD_TYPE_O <= fetched_reg && !legal_type(type_reg);
            if (fetched_reg) begin
                WR_PIXEL_MASK_O <= legal_type(type_reg) ? live : 16'h0000;
                ARRAY_INDEX_O <= (SURF_KIND_I == rt_write_pkg::SURF_LINEAR) ? rt_write_pkg::AI_ZERO :
                                 (ai_bad ? MIN_ARRAY_I : ai_raw);
                VIEWPORT_O <= hdr_rd[rt_write_pkg::W_VIEW*32 + rt_write_pkg::VP_LO +: 4];
                CC_PTR_O <= hdr0_reg[rt_write_pkg::W_CC*32 + rt_write_pkg::CC_LO +: 26];
                BACK_FACE_O <= hdr_rd[rt_write_pkg::W_FACE*32 + rt_write_pkg::FACE_BIT];
                LAST_TARGET_O <= last_reg;
                MSG_TYPE_O <= type_reg;
                SPAN_PAIR_O <= pair;
                SLOT_SAMPLE_O <= samples;
            end
        end
    end

    // completion: tag release, dispatch mask, statistics
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RELEASE_VALID_O <= 1'b0;
            THREAD_TAG_O <= 8'h00;
            DISPATCH_MASK_O <= 16'h0000;
            CLIP_DEC_O <= 5'h00;
            CLIP_DEC_VALID_O <= 1'b0;
        end else begin
            RELEASE_VALID_O <= fetched_reg && eot_reg && legal_type(type_reg);
            CLIP_DEC_VALID_O <= fetched_reg && legal_type(type_reg) && (clip_cnt != 5'h00);
            if (fetched_reg) begin
                THREAD_TAG_O <= hdr0_reg[rt_write_pkg::W_TAG*32 +: 8];
                DISPATCH_MASK_O <= hdr0_reg[rt_write_pkg::W_MASK*32 + rt_write_pkg::DISP_LO +: 16];
                CLIP_DEC_O <= clip_cnt;
            end
        end
    end

    // checks
    sequence hdr_pair_s;
        state_reg == HDR1 && take;
    endsequence

    // fetch, registered read, issue: three edges after the second take
    sequence issue_s;
        ##3 (WR_VALID_O || BAD_TYPE_O);
    endsequence

    hdr_then_issue_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        hdr_pair_s |-> issue_s) else $error("header pair not followed by issue");
    bad_type_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        BAD_TYPE_O |-> !WR_VALID_O && !RELEASE_VALID_O) else $error("reserved type had effect");
    type_decode_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg && type_reg > rt_write_pkg::TYPE_SIMD8 |=> BAD_TYPE_O) else $error("reserved missed");
    live_only_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg |=> (WR_PIXEL_MASK_O & ~$past(hdr0_reg[15:0])) == 16'h0000)
        else $error("dead pixel written");
    bounds_drop_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg |=> (WR_PIXEL_MASK_O & ~$past(in_bounds)) == 16'h0000)
        else $error("out-of-bounds pixel written");
    array_clamp_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg && ai_bad && SURF_KIND_I != rt_write_pkg::SURF_LINEAR && legal_type(type_reg)
        |=> ARRAY_INDEX_O == $past(MIN_ARRAY_I) && WR_VALID_O) else $error("array index not clamped");
    release_tag_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        RELEASE_VALID_O |-> THREAD_TAG_O == $past(hdr0_reg[167:160])) else $error("wrong tag");
    clip_count_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg && legal_type(type_reg) |=> CLIP_DEC_O == $past(clip_cnt) &&
        CLIP_DEC_VALID_O == ($past(clip_cnt) != 5'h00)) else $error("clip count wrong");
    dual_pair_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg && type_reg == rt_write_pkg::TYPE_DUAL_HI |=> SPAN_PAIR_O == 2'h2)
        else $error("dual pair wrong");
    sample_sspi_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        fetched_reg && NUM_SAMPLES_I == rt_write_pkg::SAMP_8X
        |=> SLOT_SAMPLE_O[7:0] == 8'({$past(SSPI_I), 1'b0})) else $error("sample index wrong");
endmodule : rt_write_handler

// ==== tb/rt_thread_model.sv ====
`timescale 1ns/1ns
// thread model: offers the two header registers of each message
module rt_thread_model (
    // clock
    input wire logic clk_i,
    // message handshake
    input wire logic ready_i,
    output logic valid_o,
    output logic [255:0] data_o,
    output logic [13:0] desc_o,
    output logic eot_o,
    output logic [15:0] exec_o,
    // bounded wait ran out
    output logic hung_o
);
    initial begin
        valid_o = 1'b0;
        data_o = '0;
        desc_o = '0;
        eot_o = 1'b0;
        exec_o = '0;
        hung_o = 1'b0;
    end

    // stateless and field-mode targets are never issued; no port carries them
    task automatic wait_take();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ready_i !== 1'b1 && n < 64);
        if (ready_i !== 1'b1) hung_o <= 1'b1;
    endtask : wait_take

    task automatic send(input logic [255:0] h0, input logic [255:0] h1,
            input logic [13:0] d, input logic e);
        @(posedge clk_i);
        valid_o <= 1'b1;
        data_o <= h0;
        desc_o <= d;
        eot_o <= e;
        exec_o <= 16'($urandom());
        wait_take();
        // descriptor is only qualified with the first register
        data_o <= h1;
        desc_o <= ~d;
        eot_o <= ~e;
        wait_take();
        valid_o <= 1'b0;
        data_o <= ~h1;
    endtask : send
endmodule : rt_thread_model

// ==== tb/render_target_write_message_tb.sv ====
`timescale 1ns/1ns
// self-checking bench for the render target write message handler
module render_target_write_message_tb;
    typedef struct {
        logic bad;
        logic chkm;
        logic [15:0] mask;
        logic [45:0] fld;
        logic [1:0] pair;
        logic [31:0] samp;
        logic [31:0] smask;
        logic rel;
        logic [23:0] td;
        logic [4:0] clip;
    } note_type;
    note_type notes[$];
    int err_total = 0;
    int tests_run = 0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld, eot, rdy, hung, wv, face, last, relv, cv, badt;
    logic [255:0] dat;
    logic [13:0] desc;
    logic [15:0] exm, wm, dm;
    logic [2:0] kind = 3'h0, mty;
    logic [10:0] mina = '0, dep = '0, aio;
    logic [15:0] wid = '0, hgt = '0;
    logic [1:0] nsam = '0, sspi = '0, pr;
    logic [63:0] sx = '0, sy = '0;
    logic [3:0] vp;
    logic [25:0] cc;
    logic [31:0] ss;
    logic [7:0] tg;
    logic [4:0] cd;

    always #10 clk = ~clk;

    rt_thread_model thr (.clk_i(clk), .ready_i(rdy), .valid_o(vld), .data_o(dat),
        .desc_o(desc), .eot_o(eot), .exec_o(exm), .hung_o(hung));

    rt_write_handler dut (.REF_CLK_I(clk), .RST_I(rst), .MSG_VALID_I(vld),
        .MSG_DATA_I(dat), .DESC_I(desc), .END_OF_THREAD_I(eot), .EXEC_MASK_I(exm),
        .MSG_READY_O(rdy), .SURF_KIND_I(kind), .MIN_ARRAY_I(mina), .DEPTH_I(dep),
        .WIDTH_I(wid), .HEIGHT_I(hgt), .NUM_SAMPLES_I(nsam), .SSPI_I(sspi),
        .SPAN_X_I(sx), .SPAN_Y_I(sy), .WR_VALID_O(wv), .WR_PIXEL_MASK_O(wm),
        .ARRAY_INDEX_O(aio), .VIEWPORT_O(vp), .CC_PTR_O(cc), .BACK_FACE_O(face),
        .LAST_TARGET_O(last), .MSG_TYPE_O(mty), .SPAN_PAIR_O(pr), .SLOT_SAMPLE_O(ss),
        .RELEASE_VALID_O(relv), .THREAD_TAG_O(tg), .DISPATCH_MASK_O(dm),
        .CLIP_DEC_O(cd), .CLIP_DEC_VALID_O(cv), .BAD_TYPE_O(badt));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    // outputs settle by the falling edge, so no race with the launch edge
    always @(negedge clk) begin
        note_type n;
        if (hung === 1'b1) begin
            err_total++;
            summarize();
        end
        if (wv === 1'b1 || badt === 1'b1) begin
            n = notes.pop_front();
            check("bad_type", n.bad, badt);
            check("wr_valid", !n.bad, wv);
            check("release", n.rel, relv);
            check("clip_valid", n.clip != 0, cv);
            if (!n.bad) begin
                check("fields", n.fld, {aio, vp, cc, face, last, mty});
                check("slot_sample", n.samp, ss & n.smask);
                check("span_pair", n.pair, pr);
                if (n.chkm) check("pixel_mask", n.mask, wm);
                if (n.rel) check("tag_disp", n.td, {tg, dm});
                if (n.clip != 0) check("clip_count", n.clip, cd);
            end
        end
    end

    task automatic one_msg(input int i);
        logic [255:0] h0, h1;
        logic [13:0] d;
        logic [2:0] ty, kd;
        logic [1:0] ns, sp;
        logic [10:0] a, mn, dp, hi;
        logic [15:0] w, h;
        logic [63:0] x, y;
        logic [16:0] px, py;
        note_type n;
        // all eight codes first, reserved ones included
        ty = (i < 8) ? 3'(i) : 3'($urandom_range(7));
        kd = 3'($urandom_range(4));
        ns = 2'($urandom_range(2));
        sp = 2'($urandom_range(3));
        mn = 11'($urandom_range(3));
        dp = 11'($urandom_range(10));
        w = 16'($urandom_range(10, 1));
        h = 16'($urandom_range(10, 1));
        for (int k = 0; k < 8; k++) begin
            h0[32*k+:32] = $urandom();
            h1[32*k+:32] = $urandom();
        end
        h1[250:240] = (kd == rt_write_pkg::SURF_LINEAR) ? 11'h000 : 11'($urandom_range(12));
        if (i % 4 == 0) h1[239:224] = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            x[16*k+:16] = 16'($urandom_range(9));
            y[16*k+:16] = 16'($urandom_range(9));
        end
        if (kd == rt_write_pkg::SURF_ONE_DIM || kd == rt_write_pkg::SURF_LINEAR) y = '0;
        d = 14'($urandom());
        d[10:8] = ty;
        hi = (kd == rt_write_pkg::SURF_CUBE) ? rt_write_pkg::CUBE_DEPTH : dp;
        a = h1[250:240];
        if (kd == rt_write_pkg::SURF_LINEAR) a = rt_write_pkg::AI_ZERO;
        else if (a < mn || a > hi) a = mn;
        n.bad = (ty > rt_write_pkg::TYPE_SIMD8);
        n.fld = {a, h1[254:251], h0[63:38], h1[223], d[11], ty};
        n.rel = d[13] & !n.bad;
        n.td = {h0[167:160], h0[31:16]};
        n.clip = n.bad ? 5'h00 : 5'($countones(h1[239:224]));
        n.pair = (ty == rt_write_pkg::TYPE_DUAL_HI) ? 2'h2 : 2'h0;
        n.chkm = (ty <= rt_write_pkg::TYPE_REPLICATED);
        n.smask = n.chkm ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        for (int g = 0; g < 4; g++) begin
            if (ns == rt_write_pkg::SAMP_1X) n.samp[8*g+:8] = 8'h00;
            else if (ns == rt_write_pkg::SAMP_4X && n.chkm) n.samp[8*g+:8] = 8'(g);
            else n.samp[8*g+:8] = 8'(2 * sp + g);
        end
        n.samp = n.samp & n.smask;
        for (int s = 0; s < 16; s++) begin
            // pixel 0 upper left, 1 upper right, 2 lower left, 3 lower right
            px = {1'b0, x[16*((ns == 2'h0) ? s / 4 : 0)+:16]} + 17'(s % 2);
            py = {1'b0, y[16*((ns == 2'h0) ? s / 4 : 0)+:16]} + 17'((s % 4) / 2);
            n.mask[s] = h0[s] && px < {1'b0, w} && (py < {1'b0, h}
                || kd == rt_write_pkg::SURF_ONE_DIM || kd == rt_write_pkg::SURF_LINEAR);
        end
        repeat (3) @(posedge clk);
        kind <= kd;
        mina <= mn;
        dep <= dp;
        wid <= w;
        hgt <= h;
        nsam <= ns;
        sspi <= sp;
        sx <= x;
        sy <= y;
        notes.push_back(n);
        thr.send(h0, h1, d, d[13]);
    endtask : one_msg

    initial begin
        #2000000;
        err_total++;
        summarize();
    end

    initial begin
        void'($urandom(7414));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 80; i++) one_msg(i);
        repeat (10) @(posedge clk);
        check("notes_left", 64'h0, 64'(notes.size()));
        summarize();
    end
endmodule : render_target_write_message_tb
